/* shared/shs_pkg.sv */
// Purpose: Constants and carriers for the spindle home search sequencer
// Assumes: 20 MHz clock; settings arrive as static levels from the drive
// Notes:   Speeds in 0.01 Hz units, gain in 0.01 rad/s, delay in 10 ms units
package shs_pkg;
    localparam int CLK_HZ           = 20_000_000;
    localparam int DELAY_UNIT_MS    = 10;
    localparam int DELAY_UNIT_CYC   = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam int STOP_POINTS      = 4096;
    localparam int STOP_BITS        = 12;
    localparam int PPR_MIN          = 128;
    localparam int PPR_MAX          = 65535;
    localparam int SPEED_MAX        = 12000;
    localparam int GAIN_MAX         = 10000;
    localparam int WINDOW_MAX       = 10000;
    localparam int DELAY_MAX        = 999;
    localparam logic [1:0] DIR_FWD  = 2'h0;
    localparam logic [1:0] DIR_REV  = 2'h1;
    localparam logic [5:0] IN_FUNC_ORIENT = 6'h2D;
    localparam logic [4:0] OUT_FUNC_DONE  = 5'h17;
    localparam int N_IN_TERM        = 8;
    localparam int N_OUT_TERM       = 6;

    typedef struct packed {
        logic [16:0] encoder_pulses_per_turn_setting;
        logic [11:0] stop_position_setting;
        logic [13:0] search_speed_setting;
        logic [1:0]  search_direction_setting;
        logic [13:0] completion_window_setting;
        logic [9:0]  completion_delay_setting;
        logic [13:0] position_loop_gain_setting;
    } shs_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACCEL, ST_SEEK, ST_POSITION, ST_SETTLE, ST_LOCK
    } shs_state_t;
endpackage

/* logic/shs_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are slow levels from terminals or the encoder
// Notes:   First stage feeds only the second stage
module shs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

/* logic/shs_home_search.sv */
// Purpose: Home search (spindle orientation) sequencer
// Assumes: Encoder count and speed feedback come from same-clock logic
// Notes:   Speed/position commands feed the drive's motor control loop
//
// Behaviour
// RULE_01: Run with orientation: accelerate to search speed
// RULE_02: Already running: switch to search speed
// RULE_03: At speed, first index pulse starts positioning
// RULE_04: Target is stop point plus one/two turns
// RULE_05: Deceleration set by loop gain, not time
// RULE_06: Done after delay once inside completion window
// RULE_07: Done holds until orientation request drops
// RULE_08: Servo lock holds until run command drops
// RULE_09: Stop point is one of 4096 divisions
// RULE_10: Reference point is the detected index pulse
// RULE_11: Encoder must supply index pulse on pair
// RULE_12: Input function 45 selects orientation request
// RULE_13: Output function 23 carries positioning done
// RULE_14: Pulses per turn accepted from 128 to 65535
// RULE_15: Absolute positioning mode disables home search
// RULE_16: User should keep search speed low
// RULE_17: Direction code 00 forward, 01 reverse
module shs_home_search (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      run_command,
    input  wire logic                      absolute_positioning_mode,
    input  wire logic [7:0]                input_terminals,
    input  wire logic [47:0]               input_terminal_function_select,
    input  wire logic [24:0]               output_terminal_function_select,
    input  wire logic [4:0]                relay_terminal_function_select,
    input  wire logic                      index_pulse_positive_input,
    input  wire logic                      index_pulse_negative_input,
    input  wire logic [31:0]               encoder_count,
    input  wire logic [13:0]               motor_speed,
    input  wire shs_pkg::shs_cfg_t         cfg,
    output logic                           search_active,
    output logic                           position_mode,
    output logic [13:0]                    speed_command,
    output logic                           speed_direction_reverse,
    output logic [31:0]                    position_target,
    output logic [13:0]                    position_gain,
    output logic                           servo_lock,
    output logic                           positioning_done_output,
    output logic [4:0]                     output_terminals,
    output logic                           relay_output,
    output logic                           setting_error
);
    logic [9:0]          pins_sync;
    logic                index_prev;
    shs_pkg::shs_state_t state;
    shs_pkg::shs_state_t next_state;
    logic [31:0]         ref_count;
    logic [19:0]         delay_cyc;
    logic [9:0]          delay_units;
    logic                done;

    // Index legs pass the synchroniser apart; gating raw pins first could glitch
    shs_sync #(.W(10)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({input_terminals, index_pulse_positive_input, index_pulse_negative_input}),
        .dout (pins_sync)
    );

    // Orientation request is the OR of every terminal assigned function 45
    logic [7:0] orient_hits;
    genvar gi;
    generate
        for (gi = 0; gi < shs_pkg::N_IN_TERM; gi++) begin : g_in
            assign orient_hits[gi] = pins_sync[gi+2]
                & (input_terminal_function_select[gi*6 +: 6] == shs_pkg::IN_FUNC_ORIENT); // RULE_12
        end
        for (gi = 0; gi < 5; gi++) begin : g_out
            assign output_terminals[gi] = positioning_done_output
                & (output_terminal_function_select[gi*5 +: 5] == shs_pkg::OUT_FUNC_DONE); // RULE_13
        end
    endgenerate

    wire orient_req   = |orient_hits;
    wire index_level  = pins_sync[1] & ~pins_sync[0];
    wire index_edge   = index_level & ~index_prev; // RULE_10
    wire ppr_ok       = (cfg.encoder_pulses_per_turn_setting >= 17'(shs_pkg::PPR_MIN))
                      && (cfg.encoder_pulses_per_turn_setting <= 17'(shs_pkg::PPR_MAX)); // RULE_14
    wire dir_ok       = (cfg.search_direction_setting == shs_pkg::DIR_FWD)
                      || (cfg.search_direction_setting == shs_pkg::DIR_REV);
    wire enable       = orient_req & run_command & ~absolute_positioning_mode & ppr_ok & dir_ok; // RULE_15
    wire reverse      = (cfg.search_direction_setting == shs_pkg::DIR_REV); // RULE_17
    wire at_speed     = (motor_speed >= cfg.search_speed_setting);

    // Stop point scaled from 4096 divisions to encoder pulses by multiplying by PPR and shifting right 12 bits
    wire [28:0] stop_scaled = 29'(cfg.stop_position_setting) * 29'(cfg.encoder_pulses_per_turn_setting); // RULE_09
    wire [31:0] stop_pulses = 32'(stop_scaled >> shs_pkg::STOP_BITS);
    wire [31:0] ppr32       = 32'(cfg.encoder_pulses_per_turn_setting);
    wire [31:0] turns       = reverse ? (ppr32 << 1) : ppr32;
    // Reverse motion counts down, so the target lies below the reference
    wire [31:0] next_target = reverse ? (encoder_count - stop_pulses - turns)
                                      : (encoder_count + stop_pulses + turns); // RULE_04
    wire [31:0] diff        = position_target - encoder_count;
    wire [31:0] remaining   = diff[31] ? (32'h0 - diff) : diff;
    wire        in_window   = (remaining <= 32'(cfg.completion_window_setting));
    wire        delay_over  = (delay_units >= cfg.completion_delay_setting);

    always_comb begin
        next_state = state;
        if (!enable && state != shs_pkg::ST_LOCK) begin
            next_state = shs_pkg::ST_IDLE;
        end else begin
            case (state)
                shs_pkg::ST_IDLE:     next_state = shs_pkg::ST_ACCEL; // RULE_01 RULE_02
                shs_pkg::ST_ACCEL:    if (at_speed) next_state = shs_pkg::ST_SEEK;
                shs_pkg::ST_SEEK:     if (index_edge) next_state = shs_pkg::ST_POSITION; // RULE_03
                shs_pkg::ST_POSITION: if (in_window) next_state = shs_pkg::ST_SETTLE;
                shs_pkg::ST_SETTLE: begin
                    if (!in_window) next_state = shs_pkg::ST_POSITION;
                    else if (delay_over) next_state = shs_pkg::ST_LOCK; // RULE_06
                end
                shs_pkg::ST_LOCK:     if (!run_command) next_state = shs_pkg::ST_IDLE; // RULE_08
                default:              next_state = shs_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= shs_pkg::ST_IDLE;
            index_prev <= 1'b0;
        end else begin
            state      <= next_state;
            index_prev <= index_level;
        end
    end

    // Reference captured on the very edge that enters positioning
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            position_target <= '0;
        end else if (state == shs_pkg::ST_SEEK && index_edge) begin
            position_target <= next_target; // RULE_04 RULE_10
        end
    end

    // Completion delay in 10 ms units; restarts if the count leaves the window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            delay_cyc   <= '0;
            delay_units <= '0;
        end else if (state != shs_pkg::ST_SETTLE) begin
            delay_cyc   <= '0;
            delay_units <= '0;
        end else if (delay_cyc == 20'(shs_pkg::DELAY_UNIT_CYC - 1)) begin
            delay_cyc   <= '0;
            delay_units <= delay_over ? delay_units : delay_units + 10'h1; // RULE_06
        end else begin
            delay_cyc   <= delay_cyc + 20'h1;
        end
    end

    // Done latches; only the orientation request dropping releases it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
        end else if (!orient_req) begin
            done <= 1'b0; // RULE_07
        end else if (state == shs_pkg::ST_SETTLE && in_window && delay_over) begin
            done <= 1'b1; // RULE_06
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            search_active           <= 1'b0;
            position_mode           <= 1'b0;
            speed_command           <= '0;
            speed_direction_reverse <= 1'b0;
            position_gain           <= '0;
            servo_lock              <= 1'b0;
            positioning_done_output <= 1'b0;
            relay_output            <= 1'b0;
            setting_error           <= 1'b0;
        end else begin
            search_active           <= (next_state != shs_pkg::ST_IDLE);
            position_mode           <= (next_state == shs_pkg::ST_POSITION)
                                     || (next_state == shs_pkg::ST_SETTLE)
                                     || (next_state == shs_pkg::ST_LOCK); // RULE_03
            // Search speed held constant until the index lock; keep it low to avoid regen trips
            speed_command           <= (next_state == shs_pkg::ST_ACCEL || next_state == shs_pkg::ST_SEEK)
                                     ? cfg.search_speed_setting : 14'h0; // RULE_01 RULE_02 RULE_16
            speed_direction_reverse <= reverse; // RULE_17
            // Loop gain shapes the stopping ramp; decel time setting is bypassed
            position_gain           <= cfg.position_loop_gain_setting; // RULE_05
            servo_lock              <= (next_state == shs_pkg::ST_LOCK); // RULE_08
            positioning_done_output <= done;
            relay_output            <= done & (relay_terminal_function_select == shs_pkg::OUT_FUNC_DONE); // RULE_13
            setting_error           <= orient_req & run_command & (~ppr_ok | ~dir_ok);
        end
    end
endmodule

/* sim/shs_home_search_asserts.sv */
// Purpose: Port checks for the home search sequencer
// Assumes: Settings stay put during a search
// Notes:   Orientation request is decoded from the raw pins
module shs_chk (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              run_command,
    input wire logic              absolute_positioning_mode,
    input wire logic [7:0]        input_terminals,
    input wire logic [47:0]       input_terminal_function_select,
    input wire logic [24:0]       output_terminal_function_select,
    input wire logic [13:0]       motor_speed,
    input wire shs_pkg::shs_cfg_t cfg,
    input wire logic              search_active,
    input wire logic              position_mode,
    input wire logic [13:0]       speed_command,
    input wire logic              servo_lock,
    input wire logic              positioning_done_output,
    input wire logic [4:0]        output_terminals,
    input wire logic              setting_error
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] orq;
    logic [4:0] omask;
    logic       orient_now;
    for (genvar i = 0; i < 8; i++) begin : g_in
        assign orq[i] = input_terminal_function_select[i*6+:6] == shs_pkg::IN_FUNC_ORIENT;
    end
    for (genvar i = 0; i < 5; i++) begin : g_out
        assign omask[i] = output_terminal_function_select[i*5+:5] == shs_pkg::OUT_FUNC_DONE;
    end
    assign orient_now = |(orq & input_terminals);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_speed_search: assert property (search_active && !position_mode
        |-> speed_command == cfg.search_speed_setting) else $error("search speed wrong");
    chk_index_speed: assert property ($rose(position_mode)
        |-> $past(motor_speed) >= cfg.search_speed_setting) else $error("index before speed");
    chk_done_hold: assert property (positioning_done_output && orient_now
        && $past(orient_now) && $past(orient_now, 2) && $past(orient_now, 3)
        |=> positioning_done_output) else $error("done dropped");
    chk_done_routed: assert property (output_terminals
        == ({5{positioning_done_output}} & omask)) else $error("done routing wrong");
    chk_lock_holds: assert property (servo_lock && run_command |=> servo_lock)
        else $error("lock lost");
    chk_run_release: assert property ($fell(run_command)
        |-> ##[1:2] (!servo_lock && !search_active)) else $error("lock kept");
    chk_abs_blocks: assert property (absolute_positioning_mode && !search_active
        |=> !search_active) else $error("search in abs mode");
    chk_bad_idle: assert property (setting_error |-> !search_active)
        else $error("bad settings ran");
    cover property ($rose(positioning_done_output));
    cover property ($rose(setting_error));
    cover property ($fell(run_command) && servo_lock);
    cover property (search_active && !position_mode && motor_speed > cfg.search_speed_setting);
endmodule

bind shs_home_search shs_chk u_chk (.clk, .nrst, .run_command, .absolute_positioning_mode, .input_terminals,
    .input_terminal_function_select, .output_terminal_function_select, .motor_speed, .cfg, .search_active,
    .position_mode, .speed_command, .servo_lock, .positioning_done_output, .output_terminals, .setting_error);

/* sim/shs_enc_model.sv */
// Purpose: Motor and encoder stand-in
// Assumes: One count per cycle while turning
// Notes:   Index is a level while the count sits on a turn boundary
module shs_enc_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [13:0] speed_command,
    input  wire logic        speed_direction_reverse,
    input  wire logic        position_mode,
    input  wire logic [31:0] position_target,
    input  wire logic        search_active,
    input  wire logic [13:0] base_speed,
    input  wire logic [13:0] ramp,
    input  wire logic [16:0] ppr,
    output logic      [31:0] encoder_count,
    output logic      [13:0] motor_speed,
    output logic             index_pulse_positive_input,
    output logic             index_pulse_negative_input
);
    timeunit 1ns;
    timeprecision 1ns;
    int want;
    int d;
    assign want = search_active ? int'(speed_command) : int'(base_speed);
    assign d = int'(position_target - encoder_count);
    assign index_pulse_positive_input = (ppr != 17'h0) && (int'(encoder_count) % int'(ppr) == 0);
    assign index_pulse_negative_input = !index_pulse_positive_input;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            encoder_count <= 32'h0;
            motor_speed <= 14'h0;
        end else if (position_mode) begin
            motor_speed <= 14'h0;
            encoder_count <= encoder_count + 32'((d > 0) ? 1 : ((d < 0) ? -1 : 0));
        end else begin
            // Slow ramps stand for a heavy spindle
            if (int'(motor_speed) + int'(ramp) < want) motor_speed <= motor_speed + ramp;
            else if (int'(motor_speed) > want + int'(ramp)) motor_speed <= motor_speed - ramp;
            else motor_speed <= 14'(want);
            if (motor_speed != 14'h0) encoder_count <= encoder_count + (speed_direction_reverse ? 32'hFFFFFFFF : 32'h1);
        end
    end
endmodule

/* sim/test_spindle_home_search_control.sv */
// Purpose: Self-checking bench for the home search sequencer
// Assumes: Completion delay 0, since one delay step is 200000 cycles
// Notes:   Settings change only while idle
module test_spindle_home_search_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0, nrst = 1'b0, run_command = 1'b0, absolute_positioning_mode = 1'b0;
    logic [7:0]        input_terminals = 8'h0;
    logic [47:0]       input_terminal_function_select = 48'h0;
    logic [24:0]       output_terminal_function_select = 25'h0;
    logic [4:0]        relay_terminal_function_select = 5'h0, m;
    logic [13:0]       base_speed = 14'h0, ramp = 14'h64, motor_speed, speed_command, position_gain;
    logic [31:0]       encoder_count, position_target;
    logic [4:0]        output_terminals;
    logic              index_pulse_positive_input, index_pulse_negative_input, search_active, position_mode;
    logic              speed_direction_reverse, servo_lock, positioning_done_output, relay_output, setting_error;
    shs_pkg::shs_cfg_t cfg = '{17'h80, 12'h0, 14'h0, 2'h0, 14'h3, 10'h0, 14'h0};
    int                num_errors = 0, checked = 0, cycles = 0, seed = 68480, n, t, ppr, off, r, p;
    shs_home_search u_dut (.clk, .nrst, .run_command, .absolute_positioning_mode, .input_terminals,
        .input_terminal_function_select, .output_terminal_function_select, .relay_terminal_function_select,
        .index_pulse_positive_input, .index_pulse_negative_input, .encoder_count, .motor_speed, .cfg,
        .search_active, .position_mode, .speed_command, .speed_direction_reverse, .position_target,
        .position_gain, .servo_lock, .positioning_done_output, .output_terminals, .relay_output, .setting_error);
    shs_enc_model u_enc (.clk, .nrst, .speed_command, .speed_direction_reverse, .position_mode, .position_target,
        .search_active, .base_speed, .ramp, .ppr(cfg.encoder_pulses_per_turn_setting), .encoder_count,
        .motor_speed, .index_pulse_positive_input, .index_pulse_negative_input);
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (exp !== got) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        for (n = 0; n < 8; n++) begin
            ppr = 128 + {$random(seed)} % 300;
            t = {$random(seed)} % 8;
            // Search speed kept moderate so the one- or two-turn stop stays gentle on the bus
            cfg = '{17'(ppr), 12'((n == 0) ? 0 : (n == 1) ? 4095 : $random(seed)),
                14'(500 + {$random(seed)} % 5500), 2'(n % 2), 14'h3, 10'h0, 14'($random(seed))};
            off = int'(cfg.stop_position_setting) * ppr / 4096;
            input_terminal_function_select = 48'({$random(seed), $random(seed)});
            input_terminal_function_select[t*6+:6] = shs_pkg::IN_FUNC_ORIENT;
            output_terminal_function_select = 25'($random(seed));
            output_terminal_function_select[(n%5)*5+:5] = shs_pkg::OUT_FUNC_DONE;
            for (r = 0; r < 5; r++) m[r] = output_terminal_function_select[r*5+:5] == shs_pkg::OUT_FUNC_DONE;
            relay_terminal_function_select = (n % 3) ? shs_pkg::OUT_FUNC_DONE : 5'h0;
            ramp = 14'(50 + {$random(seed)} % 2000);
            base_speed = (n % 4 >= 2) ? 14'(1000 + {$random(seed)} % 11000) : 14'h0;
            run_command = 1'b1;
            // Already running: orientation comes late
            if (n % 4 >= 2) repeat (300) @(negedge clk);
            input_terminals = 8'h1 << t;
            r = 0;
            while (positioning_done_output !== 1'b1 && r < 20000) begin
                @(negedge clk);
                r++;
            end
            @(negedge clk);
            p = int'(position_target) - ((n % 2) ? -(off + 2 * ppr) : off + ppr);
            r = ((p % ppr) + ppr) % ppr;
            check("done", 1, positioning_done_output);
            check("reference", 1, r <= 5 || r >= ppr - 5);
            check("terminals", m, output_terminals);
            check("relay", n % 3 != 0, relay_output);
            check("gain", cfg.position_loop_gain_setting, position_gain);
            check("direction", n % 2, speed_direction_reverse);
            repeat (20) @(negedge clk);
            check("done held", 1, positioning_done_output);
            input_terminals = 8'h0;
            repeat (5) @(negedge clk);
            check("done off", 0, positioning_done_output);
            check("lock", 1, servo_lock);
            run_command = 1'b0;
            base_speed = 14'h0;
            repeat (3) @(negedge clk);
            check("unlock", 0, servo_lock);
        end
        for (n = 0; n < 3; n++) begin
            absolute_positioning_mode = (n == 0);
            cfg.encoder_pulses_per_turn_setting = (n == 1) ? 17'h64 : 17'h80;
            cfg.search_direction_setting = (n == 2) ? 2'h2 : 2'h0;
            input_terminals = 8'h1 << t;
            run_command = 1'b1;
            repeat (10) @(negedge clk);
            check("active", 0, search_active);
            check("error", n != 0, setting_error);
            run_command = 1'b0;
            input_terminals = 8'h0;
            @(negedge clk);
        end
        end_sim();
    end
endmodule
